// >>> irq_accept_seq.sv
// Functional notes
// - Six special sources non-maskable, peripherals maskable
// - Maskable needs enable, source level, processor level
// - Software requests: trap, break, overflow, undefined
// - Ordinary instruction finishes, resolve, sequence next
// - String and multiply-accumulate suspend partway
// - Push pre-acceptance flags and PC first
// - Load new flag and processor priority level
// - During sequence ignore all but reset
// - After sequence start the service routine
//
// Interrupt acceptance sequencer with APB register port.
// Assumes the core reports instruction boundaries and suspendable instructions.
//
// The register offsets and the APB register port were decided locally.
`timescale 1ns/1ps
`include "irq_accept_map.svh"
module irq_accept_seq #(
    parameter int N_PERIPH = 8,
    parameter int PC_W = 20
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    // Core handshake
    input wire logic i_insn_done,
    input wire logic i_insn_suspendable,
    input wire logic i_insn_resumable,
    input wire logic [15:0] i_flags,
    input wire logic [PC_W-1:0] i_pc,
    input wire logic i_reti,
    // Request sources
    input wire logic [`IA_N_SPECIAL-1:0] i_special_req,
    input wire logic i_trap_instruction,
    input wire logic i_break_instruction,
    input wire logic i_overflow_trap,
    input wire logic i_undefined_instruction,
    input wire logic [N_PERIPH-1:0] i_periph_req,
    input wire logic [N_PERIPH*3-1:0] i_periph_lvl,
    // APB
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    // Core outputs
    output logic o_suspend,
    output logic o_push_valid,
    output logic [15:0] o_push_flags,
    output logic [PC_W-1:0] o_push_pc,
    output logic o_handler_start,
    output logic [7:0] o_vector,
    output logic o_resume_suspended,
    output logic o_irq
);
    import irq_accept_pkg::*;

    // Vector field and read word limit the widths
    if (N_PERIPH < 1 || N_PERIPH > 64) begin : g_bad_periph
        $error("N_PERIPH out of range");
    end
    if (PC_W < 1 || PC_W > 32) begin : g_bad_pc
        $error("PC_W out of range");
    end

    // ----------------------------------------
    // State
    // ----------------------------------------
    seq_state_t state_q, state_d;
    logic ien_q;
    logic [2:0] ppl_q;
    logic [2:0] status_q;
    logic [2:0] mask_q;
    logic [15:0] saved_flags_q;
    logic [PC_W-1:0] saved_pc_q;
    logic [7:0] vector_q;
    logic [2:0] new_lvl_q;
    logic was_suspended_q;
    logic in_handler_q;
    logic [31:0] prdata_q;
    logic pready_q;
    logic pslverr_q;
    logic suspend_q, push_q, hstart_q, resume_q, irq_q;
    logic [`IA_N_SOFT-1:0] soft_req;

    irq_pick_if #(.N_PERIPH(N_PERIPH)) pick ();

    assign soft_req = {i_undefined_instruction, i_overflow_trap,
                       i_break_instruction, i_trap_instruction};

    irq_priority_pick #(.N_PERIPH(N_PERIPH)) u_pick (
        .i_special(i_special_req),
        .i_soft(soft_req),
        .i_periph(i_periph_req),
        .i_periph_lvl(i_periph_lvl),
        .i_ien(ien_q),
        .i_ppl(ppl_q),
        .pick(pick)
    );

    // ----------------------------------------
    // Acceptance decode
    // ----------------------------------------
    wire reset_break = i_special_req[0];
    wire at_boundary = i_insn_done || i_insn_suspendable;
    wire accept = (state_q == ST_RUN) && pick.valid && at_boundary;
    wire mid_insn = accept && !i_insn_done && i_insn_suspendable;
    // Requests other than reset during the sequence are dropped
    wire dropped = (state_q != ST_RUN) && (state_q != ST_HANDLER)
                   && pick.valid && !reset_break;
    wire resume_now = (state_q == ST_HANDLER) && i_reti && was_suspended_q;

    // ----------------------------------------
    // APB decode
    // ----------------------------------------
    wire apb_acc = i_psel && i_penable && !pready_q;
    wire apb_wr = apb_acc && i_pwrite;
    wire apb_rd = apb_acc && !i_pwrite;
    wire hit_ctrl = i_paddr == `IA_CTRL_OFS;
    wire hit_stat = i_paddr == `IA_STATUS_OFS;
    wire hit_mask = i_paddr == `IA_MASK_OFS;
    wire hit_info = i_paddr == `IA_INFO_OFS;
    wire hit_sflg = i_paddr == `IA_SAVED_FLAG_OFS;
    wire hit_spc = i_paddr == `IA_SAVED_PC_OFS;
    wire hit_any = hit_ctrl | hit_stat | hit_mask | hit_info | hit_sflg | hit_spc;
    wire [31:0] ctrl_rd = {28'h0, ppl_q, ien_q};
    wire [31:0] info_rd = {20'h0, 1'b0, state_q, vector_q};
    wire [31:0] rd_mux = hit_ctrl ? ctrl_rd :
                         hit_stat ? {29'h0, status_q} :
                         hit_mask ? {29'h0, mask_q} :
                         hit_info ? info_rd :
                         hit_sflg ? {16'h0, saved_flags_q} :
                         hit_spc ? 32'(saved_pc_q) : 32'h0;
    wire [2:0] events = {dropped, resume_now, accept};
    wire stat_clr = apb_rd && hit_stat;
    // Set wins over read-clear
    wire [2:0] status_d = (stat_clr ? 3'h0 : status_q) | events;

    // ----------------------------------------
    // Sequencer
    // ----------------------------------------
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ST_RUN: begin
                if (accept) begin
                    state_d = ST_RESOLVE;
                end
            end
            ST_RESOLVE: begin
                state_d = ST_PUSH;
            end
            ST_PUSH: begin
                state_d = ST_LOAD;
            end
            ST_LOAD: begin
                state_d = ST_HANDLER;
            end
            ST_HANDLER: begin
                if (i_reti) begin
                    state_d = ST_RUN;
                end
            end
            default: begin
                state_d = ST_RUN;
            end
        endcase
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_q <= ST_RUN;
        end else if (reset_break && state_q != ST_RUN) begin
            state_q <= ST_RUN;
        end else begin
            state_q <= state_d;
        end
    end

    // Capture context at acceptance; later requests cannot touch it
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            saved_flags_q <= 16'h0000;
            saved_pc_q <= '0;
            vector_q <= 8'h00;
            new_lvl_q <= 3'h0;
            was_suspended_q <= 1'b0;
        end else if (accept) begin
            saved_flags_q <= i_flags;
            saved_pc_q <= i_pc;
            vector_q <= pick.vector;
            new_lvl_q <= pick.level;
            was_suspended_q <= mid_insn && i_insn_resumable;
        end else if (resume_now) begin
            was_suspended_q <= 1'b0;
        end
    end

    // Enable flag and processor level: software, sequence or return
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ien_q <= 1'b0;
            ppl_q <= 3'h0;
        end else if (state_q == ST_LOAD) begin
            ien_q <= 1'b0;
            ppl_q <= new_lvl_q;
        end else if (state_q == ST_HANDLER && i_reti) begin
            ien_q <= saved_flags_q[`IA_FLAG_IEN_BIT];
            ppl_q <= saved_flags_q[`IA_FLAG_PPL_LSB +: 3];
        end else if (apb_wr && hit_ctrl) begin
            ien_q <= i_pwdata[`IA_CTRL_IEN_BIT];
            ppl_q <= i_pwdata[`IA_CTRL_PPL_LSB +: 3];
        end
    end

    // ----------------------------------------
    // Registers and outputs
    // ----------------------------------------
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            status_q <= 3'h0;
            mask_q <= `IA_MASK_RST;
            prdata_q <= 32'h0000_0000;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
        end else begin
            status_q <= status_d;
            if (apb_wr && hit_mask) begin
                mask_q <= i_pwdata[2:0];
            end
            pready_q <= apb_acc;
            pslverr_q <= apb_acc && !hit_any;
            prdata_q <= apb_rd ? rd_mux : 32'h0000_0000;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            suspend_q <= 1'b0;
            push_q <= 1'b0;
            hstart_q <= 1'b0;
            resume_q <= 1'b0;
            irq_q <= 1'b0;
        end else begin
            suspend_q <= mid_insn;
            push_q <= state_q == ST_RESOLVE;
            hstart_q <= state_q == ST_LOAD;
            resume_q <= resume_now;
            irq_q <= |(status_d & mask_q);
        end
    end

    assign o_prdata = prdata_q;
    assign o_pready = pready_q;
    assign o_pslverr = pslverr_q;
    assign o_suspend = suspend_q;
    assign o_push_valid = push_q;
    assign o_push_flags = saved_flags_q;
    assign o_push_pc = saved_pc_q;
    assign o_handler_start = hstart_q;
    assign o_vector = vector_q;
    assign o_resume_suspended = resume_q;
    assign o_irq = irq_q;

endmodule : irq_accept_seq

// >>> irq_accept_map.svh
// Offsets, field positions, reset values and timing counts of the interrupt acceptance block.
// Assumes a 32-bit APB slave with word-aligned registers.
`ifndef IRQ_ACCEPT_MAP_SVH
`define IRQ_ACCEPT_MAP_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define IA_CTRL_OFS 12'h000
`define IA_STATUS_OFS 12'h004
`define IA_MASK_OFS 12'h008
`define IA_INFO_OFS 12'h00C
`define IA_SAVED_FLAG_OFS 12'h010
`define IA_SAVED_PC_OFS 12'h014

// ----------------------------------------
// Field positions
// ----------------------------------------
`define IA_CTRL_IEN_BIT 0
`define IA_CTRL_PPL_LSB 1
`define IA_ST_ACCEPT_BIT 0
`define IA_ST_RESUME_BIT 1
`define IA_ST_DROP_BIT 2
`define IA_FLAG_IEN_BIT 6
`define IA_FLAG_PPL_LSB 12

// ----------------------------------------
// Reset values and counts
// ----------------------------------------
`define IA_CTRL_RST 32'h0000_0000
`define IA_MASK_RST 3'h0
`define IA_N_SPECIAL 6
`define IA_N_SOFT 4
`define IA_SEQ_SAVE_CYCLES 4'h2

`endif

// >>> irq_accept_pkg.sv
// Types shared by the interrupt acceptance block.
// Assumes irq_accept_map.svh is on the include path.
package irq_accept_pkg;

    typedef enum logic [2:0] {
        ST_RUN = 3'h0,
        ST_RESOLVE = 3'h1,
        ST_PUSH = 3'h2,
        ST_LOAD = 3'h3,
        ST_HANDLER = 3'h4
    } seq_state_t;

    typedef enum logic [1:0] {
        SRC_NONE = 2'h0,
        SRC_SPECIAL = 2'h1,
        SRC_SOFT = 2'h2,
        SRC_PERIPH = 2'h3
    } src_kind_t;

endpackage : irq_accept_pkg

// >>> irq_pick_if.sv
// Carries the winning request from the priority picker to the sequencer.
// Assumes both ends run on the one CPU clock.
`timescale 1ns/1ps
interface irq_pick_if #(parameter int N_PERIPH = 8);
    logic valid;
    logic [7:0] vector;
    logic [2:0] level;
    irq_accept_pkg::src_kind_t kind;
    modport picker (output valid, output vector, output level, output kind);
    modport seq (input valid, input vector, input level, input kind);
endinterface : irq_pick_if

// >>> irq_priority_pick.sv
// Combinational priority resolution among pending interrupt requests.
// Assumes request inputs are levels synchronous to the CPU clock.
`timescale 1ns/1ps
`include "irq_accept_map.svh"
module irq_priority_pick #(
    parameter int N_PERIPH = 8
) (
    input wire logic [`IA_N_SPECIAL-1:0] i_special,
    input wire logic [`IA_N_SOFT-1:0] i_soft,
    input wire logic [N_PERIPH-1:0] i_periph,
    input wire logic [N_PERIPH*3-1:0] i_periph_lvl,
    input wire logic i_ien,
    input wire logic [2:0] i_ppl,
    irq_pick_if.picker pick
);
    import irq_accept_pkg::*;

    logic [N_PERIPH-1:0] eligible;
    logic [2:0] best_lvl [0:N_PERIPH];
    logic [7:0] best_idx [0:N_PERIPH];
    logic best_hit [0:N_PERIPH];
    logic [7:0] spec_idx;
    logic [7:0] soft_idx;

    // ----------------------------------------
    // Maskable gating and per-source level compare
    // ----------------------------------------
    assign best_lvl[0] = 3'h0;
    assign best_idx[0] = 8'h00;
    assign best_hit[0] = 1'b0;
    genvar g;
    generate
        for (g = 0; g < N_PERIPH; g++) begin : g_per
            logic [2:0] lvl;
            logic win;
            assign lvl = i_periph_lvl[g*3 +: 3];
            // Flag, level select and processor level all gate
            assign eligible[g] = i_periph[g] && i_ien && (lvl != 3'h0) && (lvl > i_ppl);
            assign win = eligible[g] && (!best_hit[g] || lvl > best_lvl[g]);
            assign best_lvl[g+1] = win ? lvl : best_lvl[g];
            assign best_idx[g+1] = win ? 8'(g) : best_idx[g];
            assign best_hit[g+1] = best_hit[g] || eligible[g];
        end
    endgenerate

    // ----------------------------------------
    // Fixed order: special, then software, then peripheral
    // ----------------------------------------
    always_comb begin
        spec_idx = 8'h00;
        for (int i = `IA_N_SPECIAL - 1; i >= 0; i--) begin
            if (i_special[i]) begin
                spec_idx = 8'(i);
            end
        end
    end

    always_comb begin
        soft_idx = 8'h00;
        for (int i = `IA_N_SOFT - 1; i >= 0; i--) begin
            if (i_soft[i]) begin
                soft_idx = 8'(i);
            end
        end
    end

    // Special sources bypass every mask
    assign pick.valid = (|i_special) || (|i_soft) || best_hit[N_PERIPH];
    assign pick.kind = (|i_special) ? SRC_SPECIAL :
                       (|i_soft) ? SRC_SOFT :
                       best_hit[N_PERIPH] ? SRC_PERIPH : SRC_NONE;
    assign pick.vector = (|i_special) ? spec_idx :
                         (|i_soft) ? 8'(soft_idx + 8'h08) :
                         8'(best_idx[N_PERIPH] + 8'h10);
    assign pick.level = (|i_special || |i_soft) ? 3'h7 : best_lvl[N_PERIPH];

endmodule : irq_priority_pick

// >>> irq_accept_seq_assertions.sv
// Concurrent checks on the ports of the interrupt acceptance sequencer.
// Assumes a bind from the testbench top file.
`timescale 1ns/1ps
module irq_accept_seq_assertions (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_insn_suspendable,
    input wire logic i_reti,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic o_pready,
    input wire logic o_pslverr,
    input wire logic o_suspend,
    input wire logic o_push_valid,
    input wire logic o_handler_start,
    input wire logic o_resume_suspended
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    // ----------------------------------------
    // Sequence steps
    // ----------------------------------------
    sequence save_s;
        o_push_valid ##[1:2] o_handler_start;
    endsequence
    sequence quiet_s;
        (!o_push_valid) [*3];
    endsequence
    suspend_push_a: assert property (o_suspend |=> o_push_valid)
        else $error("push missing after suspend");
    suspend_cause_a: assert property (o_suspend |->
        ($past(i_insn_suspendable) || $past(i_insn_suspendable, 2)))
        else $error("suspend without suspendable instruction");
    push_handler_a: assert property (o_push_valid |-> save_s)
        else $error("handler start missing after push");
    seq_ignore_a: assert property (o_push_valid |=> quiet_s)
        else $error("second push inside sequence");
    handler_cause_a: assert property (o_handler_start |->
        ($past(o_push_valid) || $past(o_push_valid, 2)))
        else $error("handler start without push");
    handler_pulse_a: assert property (o_handler_start |=> !o_handler_start)
        else $error("handler start longer than one cycle");
    resume_cause_a: assert property (o_resume_suspended |->
        ($past(i_reti) || $past(i_reti, 2)))
        else $error("resume without return");
    apb_ready_a: assert property (o_pready |-> $past(i_psel && i_penable) ##1 !o_pready)
        else $error("pready without access phase");
    apb_err_a: assert property (o_pslverr |-> o_pready)
        else $error("pslverr outside pready");
endmodule // irq_accept_seq_assertions

// >>> irq_src_model.sv
// Peripheral request sources facing the sequencer.
// Assumes vectors 16 and up name peripheral sources.
`timescale 1ns/1ps
module irq_src_model #(
    parameter int N = 8
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic [N-1:0] i_raise,
    input wire logic i_ack,
    input wire logic [7:0] i_vec,
    output logic [N-1:0] o_req
);
    logic [N-1:0] clr;
    assign clr = (i_ack && i_vec >= 8'h10) ? (N'(1) << (i_vec - 8'h10)) : '0;
    // Level held until its service starts
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) o_req <= '0;
        else o_req <= (o_req | i_raise) & ~clr;
    end
endmodule // irq_src_model

// >>> cpu_interrupt_acceptance_sequencer_tb.sv
// Self-checking bench of the interrupt acceptance sequencer.
// Assumes the design package, map header and source model are compiled first.
`timescale 1ns/1ps
`include "irq_accept_map.svh"
`define CHK(n, x, g) begin n_checks++; if ((g) !== (x)) begin err_count++; \
    $display("[ERR] %s exp %0h got %0h", n, x, g); end end
module cpu_interrupt_acceptance_sequencer_tb;
    import irq_accept_pkg::*;
    logic i_clk, i_rst_n, done, susp, resum, reti, psel, penable, pwrite, e;
    logic [15:0] flags, pf, gf, xf;
    logic [19:0] pc, pp, gp, xp;
    logic [9:0] req;
    logic [7:0] raise, preq, vec;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, sts;
    logic pready, pslverr, o_sus, pushv, hs, resume, irq, ien, sus_seen, res_seen;
    logic [2:0] ppl;
    int err_count, n_checks, seed, hs_cnt, k;
    irq_src_model #(.N(8)) irq_src_model_i (.i_clk(i_clk), .i_rst_n(i_rst_n),
        .i_raise(raise), .i_ack(hs), .i_vec(vec), .o_req(preq));
    irq_accept_seq irq_accept_seq_i (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_insn_done(done),
        .i_insn_suspendable(susp), .i_insn_resumable(resum), .i_flags(flags), .i_pc(pc),
        .i_reti(reti), .i_special_req(req[5:0]), .i_trap_instruction(req[6]),
        .i_break_instruction(req[7]), .i_overflow_trap(req[8]),
        .i_undefined_instruction(req[9]), .i_periph_req(preq), .i_periph_lvl(24'hFAC688),
        .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
        .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
        .o_suspend(o_sus), .o_push_valid(pushv), .o_push_flags(pf), .o_push_pc(pp),
        .o_handler_start(hs), .o_vector(vec), .o_resume_suspended(resume), .o_irq(irq));
    initial begin
        i_clk = 0;
        forever #5 i_clk = ~i_clk;
    end
    always @(posedge i_clk) begin
        if (pushv === 1'b1) begin
            gf <= pf;
            gp <= pp;
        end
        if (o_sus === 1'b1) sus_seen <= 1'b1;
        if (resume === 1'b1) res_seen <= 1'b1;
        if (hs === 1'b1) hs_cnt++;
    end
    task wrap_up;
        $display("checks %0d errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge i_clk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge i_clk);
        penable <= 1'b1;
        n = 0;
        do begin @(posedge i_clk); n++; end while (pready !== 1'b1 && n < 20);
        if (n == 20) begin err_count++; wrap_up; end
        rd = prdata; e = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask
    task serve(input logic [9:0] r, input logic [7:0] pr, input logic [7:0] xv, input logic dr);
        int n;
        @(posedge i_clk);
        // A request already pending is taken with the context still shown
        if (r != 10'h000 || pr != 8'h00) begin
            xf = (16'($random(seed)) & 16'h8FBF) | {1'b0, ppl, 5'h00, ien, 6'h00};
            xp = 20'($random(seed));
        end
        flags <= xf; pc <= xp; req <= r; raise <= pr;
        @(posedge i_clk);
        raise <= 8'h00;
        n = 0;
        while (hs !== 1'b1 && n < 30) begin
            @(posedge i_clk);
            n++;
            req <= (dr && pushv === 1'b1) ? (r | 10'h020) : r;
        end
        if (n == 30) begin err_count++; wrap_up; end
        `CHK("vector", xv, vec)
        `CHK("push flags", xf, gf)
        `CHK("push pc", xp, gp)
        sts = sts | 32'h1 | (dr ? 32'h4 : 32'h0);
        req <= 10'h000;
        // Peripheral levels equal their index; others run at level seven
        apb(0, `IA_CTRL_OFS, 0);
        `CHK("handler ctrl", (xv < 8'h10) ? 32'hE : {28'h0, xv[2:0], 1'b0}, rd)
        @(posedge i_clk); reti <= 1'b1;
        @(posedge i_clk); reti <= 1'b0;
        repeat (3) @(posedge i_clk);
    endtask
    initial begin
        seed = 47; err_count = 0; n_checks = 0; hs_cnt = 0; sts = 0;
        i_rst_n = 0; done = 1; susp = 0; resum = 0; reti = 0; flags = 0; pc = 0;
        req = 0; raise = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
        ien = 0; ppl = 0; sus_seen = 0; res_seen = 0;
        repeat (6) @(posedge i_clk);
        i_rst_n <= 1'b1;
        // ----------------------------------------
        // Reset values, unmapped access
        // ----------------------------------------
        apb(0, `IA_CTRL_OFS, 0); `CHK("ctrl", `IA_CTRL_RST, rd)
        apb(0, `IA_MASK_OFS, 0); `CHK("mask", 32'(`IA_MASK_RST), rd)
        apb(0, 12'h100, 0); `CHK("unmapped err", 1'b1, e)
        `CHK("unmapped data", 32'h0, rd)
        apb(0, `IA_STATUS_OFS, 0); `CHK("status", 32'h0, rd)
        // ----------------------------------------
        // Non-maskable and software sources
        // ----------------------------------------
        for (k = 1; k < `IA_N_SPECIAL; k++) serve(10'(1) << k, 0, 8'(k), k == 1);
        for (k = 0; k < `IA_N_SOFT; k++) serve(10'h040 << k, 0, 8'(8 + k), 0);
        `CHK("no suspend", 1'b0, sus_seen)
        // ----------------------------------------
        // Maskable gating and priority
        // ----------------------------------------
        k = hs_cnt;
        raise <= 8'h04;
        @(posedge i_clk); raise <= 8'h00;
        repeat (10) @(posedge i_clk);
        `CHK("held by enable", k, hs_cnt)
        apb(1, `IA_CTRL_OFS, 32'h5); ien = 1; ppl = 3'h2;
        repeat (10) @(posedge i_clk);
        `CHK("held by level", k, hs_cnt)
        serve(0, 8'h60, 8'h16, 0);
        serve(0, 0, 8'h15, 0);
        // ----------------------------------------
        // Suspend and resume
        // ----------------------------------------
        done <= 1'b0; susp <= 1'b1; resum <= 1'b1;
        serve(10'h004, 0, 8'h02, 0);
        `CHK("suspended", 1'b1, sus_seen)
        `CHK("resumed", 1'b1, res_seen)
        sts = sts | 32'h2;
        done <= 1'b1; susp <= 1'b0; resum <= 1'b0;
        // ----------------------------------------
        // Status, mask and interrupt line
        // ----------------------------------------
        `CHK("irq masked", 1'b0, irq)
        apb(1, `IA_MASK_OFS, 32'h7);
        repeat (2) @(posedge i_clk);
        `CHK("irq raised", 1'b1, irq)
        apb(0, `IA_STATUS_OFS, 0); `CHK("status bits", sts, rd)
        repeat (2) @(posedge i_clk);
        `CHK("irq cleared", 1'b0, irq)
        apb(0, `IA_STATUS_OFS, 0); `CHK("status cleared", 32'h0, rd)
        // ----------------------------------------
        // Reset in mid-run
        // ----------------------------------------
        i_rst_n <= 1'b0;
        repeat (2) @(posedge i_clk);
        i_rst_n <= 1'b1;
        apb(0, `IA_CTRL_OFS, 0); `CHK("ctrl after reset", `IA_CTRL_RST, rd)
        apb(0, `IA_MASK_OFS, 0); `CHK("mask after reset", 32'(`IA_MASK_RST), rd)
        wrap_up;
    end
endmodule // cpu_interrupt_acceptance_sequencer_tb
bind irq_accept_seq irq_accept_seq_assertions chk_i (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .i_insn_suspendable(i_insn_suspendable), .i_reti(i_reti), .i_psel(i_psel),
    .i_penable(i_penable), .o_pready(o_pready), .o_pslverr(o_pslverr), .o_suspend(o_suspend),
    .o_push_valid(o_push_valid), .o_handler_start(o_handler_start),
    .o_resume_suspended(o_resume_suspended));
